// *** hw/lfbc_cfg.svh ***
// lfbc_cfg.svh: register map, field positions and timing constants of the display timing block
`ifndef LFBC_CFG_SVH
`define LFBC_CFG_SVH
// ==========================================================
// register map
`define LFBC_ADDR_CLK 8'h96
`define LFBC_ADDR_BIAS 8'h9C
`define LFBC_ADDR_INV 8'hB1
`define LFBC_RST_BYTE 8'h00
`define LFBC_BIT_INV 6
`define LFBC_BIT_UPD 1
`define LFBC_BIT_REF 0
`define LFBC_BIT_LADDER 6
`define LFBC_BIAS_TOP 5
`define LFBC_BIAS_FULL 6'h1F
// ==========================================================
// timing
`define LFBC_SYS_HZ 100000000
`define LFBC_DISP_HZ 2048
`define LFBC_BLINK_2HZ_HALF 13'h0200
`define LFBC_BLINK_1HZ_HALF 13'h0400
`define LFBC_BLINK_SW_OFF 2'h0
`define LFBC_BLINK_SW_ON 2'h1
`define LFBC_BLINK_FIXED 2'h2
`define LFBC_MUX_RSVD 2'h0
`define LFBC_MUX_2X 2'h1
`define LFBC_MUX_4X 2'h3
`define LFBC_FD_MAX 4'hF
`define LFBC_DIV_2X_STEP 8'h04
`define LFBC_DIV_MUX_STEP 8'h02
`define LFBC_DIV_2X_SLOW 8'h80
`define LFBC_DIV_MUX_SLOW 8'h40
`define LFBC_DIV_4X_C1 8'h04
`define LFBC_DIV_MUX_C12 8'h06
`define LFBC_SLOW_RATIO 8'h10
`define LFBC_SLOW_C0 8'h02
`define LFBC_SLOW_TOP 8'h01
`define LFBC_SLOW_MUX 8'h04
`define LFBC_SLOW_2X_C1 8'h04
`define LFBC_SLOW_2X_C2 8'h06
`define LFBC_SLOW_2X_REST 8'h08
`endif

// *** hw/lfbc_pkg.sv ***
// lfbc_pkg.sv: types shared by the display timing block and its users
package lfbc_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } lfbc_sfr_s;

   typedef struct packed {
      logic blink_enable;
      logic display_clock_sel;
      logic bias_third;
      logic [1:0] multiplex_level;
   } lfbc_ctrl_s;

   typedef struct packed {
      logic seg_tick;
      logic frame_start;
      logic data_load;
      logic [1:0] com_index;
      logic frame_invert;
      logic display_blank;
   } lfbc_drive_s;

   typedef struct packed {
      logic active;
      logic [5:0] level_a;
      logic [7:0] level_b;
      logic [7:0] level_c;
   } lfbc_bias_s;
endpackage : lfbc_pkg

// *** hw/lfbc_top.sv ***
// lfbc_top.sv: frame rate, blink, inversion, refresh and bias code logic of the display driver
`timescale 1ns/1ps
`include "lfbc_cfg.svh"
module lfbc_top #(
   parameter int unsigned TICK_CYC = `LFBC_SYS_HZ / `LFBC_DISP_HZ
) (
   input wire logic clk,
   input wire logic rst,
   input wire lfbc_pkg::lfbc_sfr_s sfr,
   input wire lfbc_pkg::lfbc_ctrl_s ctrl,
   output logic [7:0] sfr_rdata,
   output lfbc_pkg::lfbc_drive_s drive,
   output lfbc_pkg::lfbc_bias_s bias
);
   import lfbc_pkg::*;
   localparam int unsigned TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
   if (TICK_CYC < 1)
   begin : g_bad_tick
      $error("TICK_CYC must be at least one");
   end

   // ==========================================================
   // segment divider, in 2048 Hz ticks
   function automatic logic [7:0] seg_div(input logic [3:0] code, input logic slow,
                                          input logic [1:0] mux);
      logic [7:0] c1;
      logic [7:0] d;
      c1 = {4'h0, code} + 8'h01;
      d = `LFBC_DIV_MUX_C12;
      if (slow)
      begin
         if (code == 4'h0)
            d = `LFBC_SLOW_C0;
         else if (code == `LFBC_FD_MAX)
            d = `LFBC_SLOW_TOP;
         else if (mux != `LFBC_MUX_2X)
            d = `LFBC_SLOW_MUX;
         else if (code == 4'h1)
            d = `LFBC_SLOW_2X_C1;
         else if (code == 4'h2)
            d = `LFBC_SLOW_2X_C2;
         else
            d = `LFBC_SLOW_2X_REST;
         d = 8'(d * `LFBC_SLOW_RATIO);
      end
      else if (mux == `LFBC_MUX_2X)
      begin
         d = (code == 4'h0) ? `LFBC_DIV_2X_SLOW : 8'(c1 * `LFBC_DIV_2X_STEP);
      end
      else
      begin
         if (code == 4'h0)
            d = `LFBC_DIV_MUX_SLOW;
         else if (code == 4'h1 && mux == `LFBC_MUX_4X)
            d = `LFBC_DIV_4X_C1;
         else if (code == 4'h1 || code == 4'h2)
            d = `LFBC_DIV_MUX_C12;
         else
            d = 8'(c1 * `LFBC_DIV_MUX_STEP);
      end
      return d;
   endfunction : seg_div

   // ==========================================================
   // registers
   logic [7:0] clk_reg_r;
   logic [6:0] bias_reg_r;
   logic inv_en_r;
   logic refresh_r;
   logic upd_r;
   logic wr_clk;
   logic wr_bias;
   logic wr_inv;
   logic [1:0] blink_src;
   logic [1:0] blink_rate;
   logic [3:0] fd_code;
   assign wr_clk = sfr.wr && sfr.addr == `LFBC_ADDR_CLK;
   assign wr_bias = sfr.wr && sfr.addr == `LFBC_ADDR_BIAS;
   assign wr_inv = sfr.wr && sfr.addr == `LFBC_ADDR_INV;
   assign blink_src = clk_reg_r[7:6];
   assign blink_rate = clk_reg_r[5:4];
   assign fd_code = clk_reg_r[3:0];

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         clk_reg_r <= `LFBC_RST_BYTE;
         bias_reg_r <= 7'h00;
      end
      else
      begin
         if (wr_clk)
            clk_reg_r <= sfr.wdata;
         if (wr_bias)
            bias_reg_r <= sfr.wdata[6:0];
      end
   end

   // reserved bits of the inversion register are not stored and read zero
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         inv_en_r <= 1'b0;
         refresh_r <= 1'b0;
      end
      else if (wr_inv)
      begin
         inv_en_r <= sfr.wdata[`LFBC_BIT_INV];
         refresh_r <= sfr.wdata[`LFBC_BIT_REF];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         sfr_rdata <= `LFBC_RST_BYTE;
      else if (sfr.rd)
      begin
         unique case (sfr.addr)
            `LFBC_ADDR_CLK: sfr_rdata <= clk_reg_r;
            `LFBC_ADDR_BIAS: sfr_rdata <= {1'b0, bias_reg_r};
            `LFBC_ADDR_INV: sfr_rdata <= {1'b0, inv_en_r, 4'h0, upd_r, refresh_r};
            default: sfr_rdata <= `LFBC_RST_BYTE;
         endcase
      end
   end

   // ==========================================================
   // 2048 Hz display tick; the 128 Hz selection is handled in the divider
   logic [TW-1:0] tick_cnt_r;
   logic tick;
   assign tick = tick_cnt_r == TW'(TICK_CYC - 1);

   always_ff @(posedge clk)
   begin
      if (rst || tick)
         tick_cnt_r <= '0;
      else
         tick_cnt_r <= tick_cnt_r + TW'(1);
   end

   // ==========================================================
   // segment clock and common scan
   logic [7:0] seg_cnt_r;
   logic [7:0] div_now;
   logic seg_edge;
   logic frame_edge;
   logic [1:0] com_r;
   logic seg_tick_r;
   logic frame_start_r;
   logic mux_ok;
   assign mux_ok = ctrl.multiplex_level != `LFBC_MUX_RSVD;
   assign div_now = seg_div(fd_code, ctrl.display_clock_sel, ctrl.multiplex_level);
   // compare with >= so a smaller divider written mid-count takes effect at once
   assign seg_edge = tick && mux_ok && seg_cnt_r >= div_now - 8'h01;
   // last common index equals the multiplex code, so the frame is mux plus one segment ticks
   assign frame_edge = seg_edge && com_r >= ctrl.multiplex_level;

   always_ff @(posedge clk)
   begin
      if (rst || !mux_ok)
         seg_cnt_r <= 8'h00;
      else if (seg_edge)
         seg_cnt_r <= 8'h00;
      else if (tick)
         seg_cnt_r <= seg_cnt_r + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (rst || !mux_ok)
         com_r <= 2'h0;
      else if (frame_edge)
         com_r <= 2'h0;
      else if (seg_edge)
         com_r <= com_r + 2'h1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         seg_tick_r <= 1'b0;
         frame_start_r <= 1'b0;
      end
      else
      begin
         seg_tick_r <= seg_edge;
         frame_start_r <= frame_edge;
      end
   end

   // ==========================================================
   // frame inversion
   logic inv_r;
   always_ff @(posedge clk)
   begin
      if (rst || !inv_en_r)
         inv_r <= 1'b0;
      else if (frame_edge)
         inv_r <= ~inv_r;
   end

   // ==========================================================
   // refresh handshake
   logic load_r;
   logic load_now;
   assign load_now = frame_edge && !refresh_r;
   always_ff @(posedge clk)
   begin
      if (rst)
         load_r <= 1'b0;
      else
         load_r <= load_now;
   end

   // a new frame's set wins over a clearing write in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
         upd_r <= 1'b0;
      else if (load_now)
         upd_r <= 1'b1;
      else if (wr_inv && !sfr.wdata[`LFBC_BIT_UPD])
         upd_r <= 1'b0;
   end

   // ==========================================================
   // blink
   logic hw_blink;
   logic [12:0] blink_cnt_r;
   logic [12:0] half_period;
   logic blink_turn;
   logic phase_r;
   logic blank_target;
   logic blank_r;
   assign hw_blink = ctrl.blink_enable && blink_src[1];
   assign half_period = (blink_src == `LFBC_BLINK_FIXED) ? `LFBC_BLINK_2HZ_HALF
                        : 13'(`LFBC_BLINK_1HZ_HALF * ({11'h000, blink_rate} + 13'h0001));
   assign blink_turn = hw_blink && tick && blink_cnt_r >= half_period - 13'h0001;

   always_ff @(posedge clk)
   begin
      if (rst || !hw_blink || blink_turn)
         blink_cnt_r <= 13'h0000;
      else if (tick)
         blink_cnt_r <= blink_cnt_r + 13'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (rst || !hw_blink)
         phase_r <= 1'b0;
      else if (blink_turn)
         phase_r <= ~phase_r;
   end

   always_comb
   begin
      if (!ctrl.blink_enable)
         blank_target = 1'b0;
      else if (blink_src == `LFBC_BLINK_SW_OFF)
         blank_target = 1'b1;
      else if (blink_src == `LFBC_BLINK_SW_ON)
         blank_target = 1'b0;
      else
         blank_target = phase_r;
   end

   // blanking only switches between frames; with no frames running it follows directly
   always_ff @(posedge clk)
   begin
      if (rst)
         blank_r <= 1'b0;
      else if (frame_edge || !mux_ok)
         blank_r <= blank_target;
   end

   // ==========================================================
   // bias level codes in units of reference/31
   logic [5:0] lvl_a;
   logic [7:0] lvl_a8;
   lfbc_bias_s bias_r;
   assign lvl_a = bias_reg_r[`LFBC_BIAS_TOP] ? `LFBC_BIAS_FULL + {1'b0, bias_reg_r[4:0]}
                  : {1'b0, bias_reg_r[4:0]};
   assign lvl_a8 = {2'h0, lvl_a};

   always_ff @(posedge clk)
   begin
      if (rst)
         bias_r <= '0;
      else
      begin
         bias_r.active <= !bias_reg_r[`LFBC_BIT_LADDER];
         bias_r.level_a <= lvl_a;
         bias_r.level_b <= ctrl.bias_third ? 8'(lvl_a8 * 8'h02) : lvl_a8;
         bias_r.level_c <= ctrl.bias_third ? 8'(lvl_a8 * 8'h03) : 8'(lvl_a8 * 8'h02);
      end
   end

   assign bias = bias_r;
   assign drive = '{seg_tick: seg_tick_r, frame_start: frame_start_r, data_load: load_r,
                    com_index: com_r, frame_invert: inv_r, display_blank: blank_r};

   // ==========================================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_inv_off: assert property (!inv_en_r |=> !inv_r)
      else $error("frame inverted while inversion disabled");
   a_inv_toggle: assert property ((inv_en_r && frame_edge) ##1 inv_en_r |-> inv_r != $past(inv_r))
      else $error("inversion did not alternate at frame start");
   a_load_cause: assert property (load_r |-> $past(frame_edge) && !$past(refresh_r))
      else $error("data load outside an unheld frame boundary");
   a_hold_noload: assert property (refresh_r && !wr_inv |=> !load_r)
      else $error("data loaded while refresh hold set");
   a_flag_set: assert property (load_r |-> upd_r)
      else $error("update flag not set on frame load");
   a_blank_sw: assert property ((ctrl.blink_enable && blink_src == `LFBC_BLINK_SW_OFF
      && frame_edge) |=> blank_r)
      else $error("software blank not applied");
   a_blink_off: assert property ((!ctrl.blink_enable && frame_edge) |=> !blank_r)
      else $error("display blanked with blink disabled");
   a_blank_frame: assert property (mux_ok && !frame_edge |=> blank_r == $past(blank_r))
      else $error("blanking changed inside a frame");
   a_blink_2hz: assert property ((hw_blink && blink_src == `LFBC_BLINK_FIXED && tick
      && blink_cnt_r == `LFBC_BLINK_2HZ_HALF - 13'h0001) |=> phase_r != $past(phase_r))
      else $error("2 Hz blink half period wrong");
   a_com_wrap: assert property (frame_edge |=> com_r == 2'h0 && frame_start_r)
      else $error("common scan did not wrap at frame start");
   a_bias_c: assert property (##1 bias_r.level_c == 8'({2'h0, bias_r.level_a}
      * ($past(ctrl.bias_third) ? 8'h03 : 8'h02)))
      else $error("top bias level not a multiple of base");
endmodule : lfbc_top

// *** tb/lfbc_glass_model.sv ***
// lfbc_glass_model.sv: passive glass model that times frames and blanking and counts data loads
`timescale 1ns/1ps
module lfbc_glass_model (
   input wire logic clk,
   input wire logic rst,
   input wire lfbc_pkg::lfbc_drive_s drive,
   output logic [31:0] frame_period,
   output logic [31:0] seg_period,
   output logic [31:0] blank_span,
   output logic [15:0] blank_changes,
   output logic [15:0] loads,
   output logic off_edge
);
   import lfbc_pkg::*;
   logic fs_d_r;
   logic blank_last_r;
   logic [31:0] fcnt_r;
   logic [31:0] bcnt_r;
   logic [31:0] scnt_r;
   // ==========================================================
   // glass observation
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fs_d_r <= 1'b0;
         blank_last_r <= 1'b0;
         fcnt_r <= 32'h0;
         bcnt_r <= 32'h0;
         frame_period <= 32'h0;
         seg_period <= 32'h0;
         scnt_r <= 32'h0;
         blank_span <= 32'h0;
         blank_changes <= 16'h0;
         loads <= 16'h0;
         off_edge <= 1'b0;
      end
      else
      begin
         fs_d_r <= drive.frame_start;
         fcnt_r <= drive.frame_start ? 32'h1 : fcnt_r + 32'h1;
         if (drive.frame_start)
            frame_period <= fcnt_r;
         scnt_r <= drive.seg_tick ? 32'h1 : scnt_r + 32'h1;
         if (drive.seg_tick)
            seg_period <= scnt_r;
         if (drive.data_load)
            loads <= loads + 16'h1;
         blank_last_r <= drive.display_blank;
         bcnt_r <= (drive.display_blank != blank_last_r) ? 32'h1 : bcnt_r + 32'h1;
         if (drive.display_blank != blank_last_r)
         begin
            blank_span <= bcnt_r;
            blank_changes <= blank_changes + 16'h1;
            // a mid-frame switch would tear the picture on the glass
            if (!drive.frame_start && !fs_d_r)
               off_edge <= 1'b1;
         end
      end
   end
endmodule : lfbc_glass_model

// *** tb/tb_lfbc_top.sv ***
// tb_lfbc_top.sv: self-checking bench for the display timing block
`timescale 1ns/1ps
module tb_lfbc_top;
   import lfbc_pkg::*;
   // short tick keeps blink periods within the run budget
   localparam int TC = 2;
   localparam logic [6:0] CF [13] = '{7'h20, 7'h23, 7'h2F, 7'h41, 7'h61, 7'h42, 7'h45,
      7'h30, 7'h7F, 7'h54, 7'h32, 7'h37, 7'h62};
   localparam logic [7:0] DV [13] = '{8'h80, 8'h10, 8'h40, 8'h06, 8'h04, 8'h06, 8'h0C,
      8'h20, 8'h10, 8'h40, 8'h60, 8'h80, 8'h06};
   logic clk = 1'b0;
   logic rst = 1'b1;
   lfbc_sfr_s sfr = '0;
   lfbc_ctrl_s ctrl = 5'h03;
   logic [7:0] sfr_rdata;
   lfbc_drive_s drive;
   lfbc_bias_s bias;
   logic [31:0] frame_period;
   logic [31:0] seg_period;
   logic [31:0] blank_span;
   logic [15:0] blank_changes;
   logic [15:0] loads;
   logic off_edge;
   int n_errors = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   lfbc_top #(.TICK_CYC(TC)) u_dut (.clk(clk), .rst(rst), .sfr(sfr), .ctrl(ctrl),
      .sfr_rdata(sfr_rdata), .drive(drive), .bias(bias));
   lfbc_glass_model u_glass (.clk(clk), .rst(rst), .drive(drive),
      .frame_period(frame_period), .seg_period(seg_period), .blank_span(blank_span),
      .blank_changes(blank_changes), .loads(loads), .off_edge(off_edge));
   // ==========================================================
   // shared tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      sfr.addr = a;
      sfr.wdata = d;
      sfr.wr = 1'b1;
      @(posedge clk);
      #1;
      sfr.wr = 1'b0;
   endtask : sfr_wr
   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      sfr.addr = a;
      sfr.rd = 1'b1;
      @(posedge clk);
      #1;
      sfr.rd = 1'b0;
      d = sfr_rdata;
   endtask : sfr_rd
   task automatic wait_frames(input int n);
      int k;
      repeat (n)
      begin
         k = 0;
         do
         begin
            @(posedge clk);
            #1;
            k++;
         end
         while (drive.frame_start !== 1'b1 && k < 4000);
         chk(k < 4000, 1'b1);
      end
      @(posedge clk);
      #1;
   endtask : wait_frames
   // blanking switches on frame edges, so a span may slip by one 32-cycle frame
   task automatic blink_span(input int exp);
      logic [15:0] c;
      int k;
      c = blank_changes;
      k = 0;
      while (blank_changes !== c + 16'h2 && k < 20000)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      checks_done++;
      if (blank_span > exp + 32 || blank_span + 32 < exp || k >= 20000)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, blank_span, exp);
      end
   endtask : blink_span
   // ==========================================================
   // scenarios
   task automatic t_regs();
      logic [7:0] d;
      foreach (CF[i])
      begin
         sfr_rd((i == 0) ? 8'h96 : (i == 1) ? 8'h9C : (i == 2) ? 8'hB1 : 8'h95, d);
         if (i < 4)
            chk(d, 8'h00);
      end
      sfr_wr(8'h96, 8'hA5);
      sfr_rd(8'h96, d);
      chk(d, 8'hA5);
      sfr_wr(8'h9C, 8'hFF);
      sfr_rd(8'h9C, d);
      chk(d, 8'h7F);
      sfr_wr(8'h95, 8'h5A);
      sfr_rd(8'h95, d);
      chk(d, 8'h00);
      sfr_wr(8'hB1, 8'h40);
      sfr_rd(8'hB1, d);
      chk(d & 8'hFD, 8'h40);
      sfr_wr(8'hB1, 8'h00);
      $display("test regs done");
   endtask : t_regs
   task automatic t_bias();
      logic [7:0] codes [5] = '{8'h00, 8'h1F, 8'h20, 8'h3F, 8'h45};
      logic [7:0] a;
      for (int t = 0; t < 2; t++)
         foreach (codes[i])
         begin
            ctrl.bias_third = t[0];
            sfr_wr(8'h9C, codes[i]);
            repeat (2) @(posedge clk);
            #1;
            a = {3'h0, codes[i][4:0]} + (codes[i][5] ? 8'h1F : 8'h00);
            chk(bias.active, {31'h0, ~codes[i][6]});
            if (!codes[i][6])
            begin
               chk(bias.level_a, a[5:0]);
               chk(bias.level_b, t[0] ? 8'(a * 2) : a);
               chk(bias.level_c, t[0] ? 8'(a * 3) : 8'(a * 2));
            end
         end
      $display("test bias done");
   endtask : t_bias
   task automatic t_divider();
      foreach (CF[i])
      begin
         ctrl.multiplex_level = CF[i][6:5];
         ctrl.display_clock_sel = CF[i][4];
         sfr_wr(8'h96, {4'h0, CF[i][3:0]});
         wait_frames(3);
         chk(frame_period, DV[i] * (CF[i][6:5] + 1) * TC);
         chk(seg_period, DV[i] * TC);
         chk(drive.com_index, 2'h0);
      end
      $display("test divider done");
   endtask : t_divider
   task automatic t_inversion();
      logic p;
      sfr_wr(8'hB1, 8'h40);
      wait_frames(2);
      repeat (4)
      begin
         p = drive.frame_invert;
         wait_frames(1);
         chk(drive.frame_invert, {31'h0, ~p});
      end
      sfr_wr(8'hB1, 8'h00);
      wait_frames(1);
      repeat (3)
      begin
         wait_frames(1);
         chk(drive.frame_invert, 1'b0);
      end
      $display("test inversion done");
   endtask : t_inversion
   task automatic t_refresh();
      logic [15:0] l;
      logic [7:0] d;
      sfr_wr(8'hB1, 8'h01);
      wait_frames(1);
      l = loads;
      wait_frames(3);
      chk(loads, l);
      sfr_rd(8'hB1, d);
      chk(d, 8'h01);
      sfr_wr(8'hB1, 8'h00);
      wait_frames(1);
      chk(loads, l + 16'h1);
      sfr_rd(8'hB1, d);
      chk(d, 8'h02);
      $display("test refresh done");
   endtask : t_refresh
   // reserved multiplex code must leave the divider idle
   task automatic t_idle();
      int n;
      n = 0;
      ctrl.multiplex_level = 2'h0;
      repeat (600)
      begin
         @(posedge clk);
         #1;
         if (drive.seg_tick !== 1'b0)
            n++;
      end
      chk(n, 0);
      $display("test idle done");
   endtask : t_idle
   task automatic t_reset();
      logic [7:0] d;
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(drive, '0);
      chk(bias, '0);
      chk(sfr_rdata, 8'h00);
      rst = 1'b0;
      sfr_rd(8'h96, d);
      chk(d, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_blink();
      logic [15:0] c;
      ctrl.multiplex_level = 2'h3;
      ctrl.display_clock_sel = 1'b0;
      ctrl.blink_enable = 1'b1;
      sfr_wr(8'h96, 8'h01);
      wait_frames(2);
      chk(drive.display_blank, 1'b1);
      sfr_wr(8'h96, 8'h41);
      wait_frames(2);
      chk(drive.display_blank, 1'b0);
      sfr_wr(8'h96, 8'hB1);
      blink_span(512 * TC);
      for (int r = 0; r < 4; r++)
      begin
         sfr_wr(8'h96, 8'hC1 | 8'(r << 4));
         blink_span(1024 * (r + 1) * TC);
      end
      ctrl.blink_enable = 1'b0;
      wait_frames(2);
      c = blank_changes;
      repeat (1200) @(posedge clk);
      #1;
      chk(blank_changes, c);
      chk(drive.display_blank, 1'b0);
      chk(off_edge, 1'b0);
      $display("test blink done");
   endtask : t_blink
   // ==========================================================
   // sequence and watchdog
   initial
   begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      t_regs();
      t_bias();
      t_divider();
      t_inversion();
      t_refresh();
      t_idle();
      t_blink();
      t_reset();
      end_sim();
   end
   initial
   begin
      repeat (80000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule : tb_lfbc_top
